// ---- hw/ltm_loop_monitor_ctl.sv ----
// How it works
// - Bit 3 of the driver enable register at 0x56 turns the monitor driver on when one and is zero after reset.
// - The two-bit source field in bits 2:1 of 0x57 mirrors the first receive port on code 01 and the second on code 10.
// - Mirrored data reaches the monitor output only while the driver enable bit is one.
// - Bit 0 of 0x63 powers the loop-through transmit stage down when one and up when zero.
// - The source-select register at 0x57 reads zero after reset, so no port is mirrored until written.
// - The power-down register at 0x63 reads zero after reset, so the transmit stage starts powered up.
// - Bit 7 of 0x52 names the first receive port when zero and the second when one.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ltm_loop_monitor_ctl (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Recovered serial data of the two receive ports
	input  wire logic        rxFirstData,
	input  wire logic        rxSecondData,
	// Monitor output pair and stage control
	output logic             monitorData,
	output logic             monitorDriveOn,
	output logic             loopTxPowerDown
);

	// Registers hold only their writable bits, so reserved bits stay zero
	logic [7:0]  portCtl_reg;
	logic [7:0]  portCtl_next;
	logic [7:0]  drvEnable_reg;
	logic [7:0]  drvEnable_next;
	logic [7:0]  srcSelect_reg;
	logic [7:0]  srcSelect_next;
	logic [7:0]  txPwdn_reg;
	logic [7:0]  txPwdn_next;
	logic        ack_reg;
	logic        ack_next;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;

	logic [7:0]  regIdx;
	logic        busReq;
	logic        busWrite;
	logic [1:0]  sourceSel;
	logic        monitorActive;
	logic [7:0]  statusWord;
	logic        srcValid;
	logic        srcMismatch;

	function automatic logic isMapped(input logic [7:0] idx);
		isMapped = (idx == ltm_pkg::IDX_PORT_CTL) || (idx == ltm_pkg::IDX_DRV_ENABLE) ||
			(idx == ltm_pkg::IDX_SRC_SELECT) || (idx == ltm_pkg::IDX_STATUS) ||
			(idx == ltm_pkg::IDX_TX_PWDN);
	endfunction : isMapped

	function automatic logic hitWrite(input logic [7:0] idx, input logic [7:0] target,
		input logic wr);
		hitWrite = wr && (idx == target);
	endfunction : hitWrite

	assign regIdx   = wb_adr_i[9:2];
	assign busReq   = wb_cyc_i && wb_stb_i && !ack_reg;
	assign busWrite = busReq && wb_we_i && wb_sel_i[0];

	assign sourceSel = srcSelect_reg[ltm_pkg::SRC_MSB:ltm_pkg::SRC_LSB];
	assign srcValid  = (sourceSel == ltm_pkg::SRC_FIRST) || (sourceSel == ltm_pkg::SRC_SECOND);

	// Port selector bit 7 names the second port when set; a mismatch with the field is flagged
	assign srcMismatch = srcValid &&
		(portCtl_reg[ltm_pkg::PORT_SEL_BIT] != (sourceSel == ltm_pkg::SRC_SECOND));

	always_comb begin
		statusWord = 8'h00;
		statusWord[ltm_pkg::ST_ACTIVE_BIT] = monitorActive;
		statusWord[ltm_pkg::ST_VALID_BIT]  = srcValid;
		statusWord[ltm_pkg::ST_MISM_BIT]   = srcMismatch;
	end

	// Register writes: only the documented bits are stored
	always_comb begin
		portCtl_next   = portCtl_reg;
		drvEnable_next = drvEnable_reg;
		srcSelect_next = srcSelect_reg;
		txPwdn_next    = txPwdn_reg;
		if (hitWrite(regIdx, ltm_pkg::IDX_PORT_CTL, busWrite)) begin
			portCtl_next = wb_dat_i[7:0] & ltm_pkg::PORT_CTL_MASK;
		end
		if (hitWrite(regIdx, ltm_pkg::IDX_DRV_ENABLE, busWrite)) begin
			drvEnable_next = wb_dat_i[7:0] & ltm_pkg::DRV_ENABLE_MASK;
		end
		if (hitWrite(regIdx, ltm_pkg::IDX_SRC_SELECT, busWrite)) begin
			srcSelect_next = wb_dat_i[7:0] & ltm_pkg::SRC_SELECT_MASK;
		end
		if (hitWrite(regIdx, ltm_pkg::IDX_TX_PWDN, busWrite)) begin
			txPwdn_next = wb_dat_i[7:0] & ltm_pkg::TX_PWDN_MASK;
		end
	end

	// Read data and acknowledge; unmapped words answer with zero
	always_comb begin
		ack_next    = busReq;
		rdData_next = rdData_reg;
		if (busReq) begin
			rdData_next = 32'h0000_0000;
			if (!wb_we_i && isMapped(regIdx)) begin
				case (regIdx)
					ltm_pkg::IDX_PORT_CTL:   rdData_next[7:0] = portCtl_reg;
					ltm_pkg::IDX_DRV_ENABLE: rdData_next[7:0] = drvEnable_reg;
					ltm_pkg::IDX_SRC_SELECT: rdData_next[7:0] = srcSelect_reg;
					ltm_pkg::IDX_STATUS:     rdData_next[7:0] = statusWord;
					ltm_pkg::IDX_TX_PWDN:    rdData_next[7:0] = txPwdn_reg;
					default:                 rdData_next[7:0] = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			portCtl_reg   <= ltm_pkg::PORT_CTL_RST;
			drvEnable_reg <= ltm_pkg::DRV_ENABLE_RST;
			srcSelect_reg <= ltm_pkg::SRC_SELECT_RST;
			txPwdn_reg    <= ltm_pkg::TX_PWDN_RST;
			ack_reg       <= 1'b0;
			rdData_reg    <= 32'h0000_0000;
		end else begin
			portCtl_reg   <= portCtl_next;
			drvEnable_reg <= drvEnable_next;
			srcSelect_reg <= srcSelect_next;
			txPwdn_reg    <= txPwdn_next;
			ack_reg       <= ack_next;
			rdData_reg    <= rdData_next;
		end
	end

	assign wb_ack_o        = ack_reg;
	assign wb_dat_o        = rdData_reg;
	assign monitorDriveOn  = drvEnable_reg[ltm_pkg::DRV_EN_BIT];
	assign loopTxPowerDown = txPwdn_reg[ltm_pkg::PWDN_BIT];

	// The pattern generator outside relies on software powering this stage down first
	ltm_mirror_path ltm_mirror_path_inst (
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.rxFirstData   (rxFirstData),
		.rxSecondData  (rxSecondData),
		.sourceSel     (sourceSel),
		.driverEn      (monitorDriveOn),
		.txPowerDown   (loopTxPowerDown),
		.monitorData   (monitorData),
		.monitorActive (monitorActive)
	);

	// Helper: high during reset and in the first cycle after reset release
	logic firstCycle_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			firstCycle_reg <= 1'b1;
		end else begin
			firstCycle_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	bus_ack_timing_a: assert property (
		busReq |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not given exactly one cycle after request");

	driver_enable_a: assert property (
		(busWrite && regIdx == ltm_pkg::IDX_DRV_ENABLE)
			|=> monitorDriveOn == $past(wb_dat_i[ltm_pkg::DRV_EN_BIT]))
		else $error("driver enable does not follow written bit 3");

	reset_values_a: assert property (
		firstCycle_reg |-> (srcSelect_reg == 8'h00 && !monitorDriveOn && !monitorActive))
		else $error("source select or driver not idle after reset");

	pwdn_reset_a: assert property (
		firstCycle_reg |-> !loopTxPowerDown)
		else $error("transmit stage not powered up after reset");

	driver_gate_a: assert property (
		!monitorDriveOn |=> !monitorData && !monitorActive)
		else $error("monitor data present while driver disabled");

	first_port_mirror_a: assert property (
		(monitorDriveOn && !loopTxPowerDown && sourceSel == ltm_pkg::SRC_FIRST)
			|=> monitorData == $past(rxFirstData, 3))
		else $error("first port data not mirrored with three cycle latency");

	second_port_mirror_a: assert property (
		(monitorDriveOn && !loopTxPowerDown && sourceSel == ltm_pkg::SRC_SECOND)
			|=> monitorData == $past(rxSecondData, 3))
		else $error("second port data not mirrored with three cycle latency");

	idle_codes_a: assert property (
		(sourceSel == ltm_pkg::SRC_NONE || sourceSel == ltm_pkg::SRC_BOTH)
			|=> !monitorActive && !monitorData)
		else $error("monitor active with an idle source code");

	tx_powerdown_a: assert property (
		(busWrite && regIdx == ltm_pkg::IDX_TX_PWDN)
			|=> loopTxPowerDown == $past(wb_dat_i[ltm_pkg::PWDN_BIT]) ##1 !monitorActive
				|| !loopTxPowerDown)
		else $error("power-down bit not taken or monitor still active");

	reserved_zero_a: assert property (
		(busReq && !wb_we_i && regIdx == ltm_pkg::IDX_DRV_ENABLE)
			|=> (wb_dat_o & ~{24'h000000, ltm_pkg::DRV_ENABLE_MASK}) == 32'h0000_0000)
		else $error("reserved bits of driver enable read non-zero");

	port_mismatch_a: assert property (
		(busReq && !wb_we_i && regIdx == ltm_pkg::IDX_STATUS)
			|=> wb_dat_o[ltm_pkg::ST_MISM_BIT]
				== $past(portCtl_reg[ltm_pkg::PORT_SEL_BIT] ? sourceSel == ltm_pkg::SRC_FIRST
					: sourceSel == ltm_pkg::SRC_SECOND))
		else $error("port selector mismatch not flagged in status");

	status_valid_a: assert property (
		(busReq && !wb_we_i && regIdx == ltm_pkg::IDX_STATUS)
			|=> wb_dat_o[ltm_pkg::ST_VALID_BIT] == $past(^sourceSel))
		else $error("source valid flag wrong in status");

	src_select_write_a: assert property (
		(busWrite && regIdx == ltm_pkg::IDX_SRC_SELECT)
			|=> sourceSel == $past(wb_dat_i[ltm_pkg::SRC_MSB:ltm_pkg::SRC_LSB]))
		else $error("source field does not follow written bits 2:1");

	port_sel_write_a: assert property (
		(busWrite && regIdx == ltm_pkg::IDX_PORT_CTL)
			|=> portCtl_reg[ltm_pkg::PORT_SEL_BIT]
				== $past(wb_dat_i[ltm_pkg::PORT_SEL_BIT]))
		else $error("port selector does not follow written bit 7");

	masked_write_a: assert property (
		busWrite |=> (portCtl_reg & ~ltm_pkg::PORT_CTL_MASK) == 8'h00
			&& (drvEnable_reg & ~ltm_pkg::DRV_ENABLE_MASK) == 8'h00
			&& (srcSelect_reg & ~ltm_pkg::SRC_SELECT_MASK) == 8'h00
			&& (txPwdn_reg & ~ltm_pkg::TX_PWDN_MASK) == 8'h00)
		else $error("reserved register bit stored by a write");

	high_bytes_zero_a: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data carries bits above the register byte");

	unmapped_zero_a: assert property (
		(busReq && !wb_we_i && !isMapped(regIdx)) |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped word reads non-zero");

	no_sel_write_a: assert property (
		(busReq && wb_we_i && !wb_sel_i[0])
			|=> $stable(portCtl_reg) && $stable(drvEnable_reg) && $stable(srcSelect_reg)
				&& $stable(txPwdn_reg))
		else $error("write without byte lane 0 changed a register");

	pwdn_idle_a: assert property (
		loopTxPowerDown |=> !monitorActive && !monitorData)
		else $error("monitor output active while transmit stage powered down");

	src_readback_a: assert property (
		(busReq && !wb_we_i && regIdx == ltm_pkg::IDX_SRC_SELECT)
			|=> wb_dat_o[ltm_pkg::SRC_MSB:ltm_pkg::SRC_LSB] == sourceSel)
		else $error("source field read back differs");

	pwdn_readback_a: assert property (
		(busReq && !wb_we_i && regIdx == ltm_pkg::IDX_TX_PWDN)
			|=> wb_dat_o == {31'h0, loopTxPowerDown})
		else $error("power-down register read back differs");

	drv_readback_a: assert property (
		(busReq && !wb_we_i && regIdx == ltm_pkg::IDX_DRV_ENABLE)
			|=> wb_dat_o[ltm_pkg::DRV_EN_BIT] == monitorDriveOn)
		else $error("driver enable bit read back differs");

	mirror_active_a: assert property (
		(monitorDriveOn && !loopTxPowerDown && srcValid) |=> monitorActive)
		else $error("monitor idle although driver on with a valid source");

	mirror_first_c: cover property (
		monitorActive && sourceSel == ltm_pkg::SRC_FIRST ##1 monitorData);

	mirror_second_c: cover property (
		monitorActive && sourceSel == ltm_pkg::SRC_SECOND ##1 monitorData);

	powered_down_c: cover property (
		monitorDriveOn && loopTxPowerDown && srcValid);

	unmapped_read_c: cover property (
		busReq && !wb_we_i && !isMapped(regIdx));

	status_read_c: cover property (
		busReq && !wb_we_i && regIdx == ltm_pkg::IDX_STATUS);

endmodule : ltm_loop_monitor_ctl

`default_nettype wire

// ---- hw/ltm_pkg.sv ----
`default_nettype none

package ltm_pkg;

	// Bus geometry: one 32-bit word per register, index = byte address / 4
	localparam int unsigned ADR_W    = 10;
	localparam int unsigned IDX_W    = 8;
	localparam int unsigned DAT_W    = 32;
	localparam int unsigned REG_W    = 8;
	localparam int unsigned SEL_W    = 4;

	// Register indices
	localparam logic [7:0] IDX_PORT_CTL   = 8'h52;
	localparam logic [7:0] IDX_DRV_ENABLE = 8'h56;
	localparam logic [7:0] IDX_SRC_SELECT = 8'h57;
	localparam logic [7:0] IDX_STATUS     = 8'h58;
	localparam logic [7:0] IDX_TX_PWDN    = 8'h63;

	// Field positions
	localparam int unsigned PORT_SEL_BIT  = 7;
	localparam int unsigned DRV_EN_BIT    = 3;
	localparam int unsigned SRC_LSB       = 1;
	localparam int unsigned SRC_MSB       = 2;
	localparam int unsigned PWDN_BIT      = 0;
	localparam int unsigned ST_ACTIVE_BIT = 0;
	localparam int unsigned ST_VALID_BIT  = 1;
	localparam int unsigned ST_MISM_BIT   = 2;

	// Writable bits; all others are reserved and read as zero
	localparam logic [7:0] PORT_CTL_MASK   = 8'h80;
	localparam logic [7:0] DRV_ENABLE_MASK = 8'h08;
	localparam logic [7:0] SRC_SELECT_MASK = 8'h06;
	localparam logic [7:0] TX_PWDN_MASK    = 8'h01;

	// Reset values
	localparam logic [7:0] PORT_CTL_RST   = 8'h00;
	localparam logic [7:0] DRV_ENABLE_RST = 8'h00;
	localparam logic [7:0] SRC_SELECT_RST = 8'h00;
	localparam logic [7:0] TX_PWDN_RST    = 8'h00;

	// Source-select codes
	localparam logic [1:0] SRC_NONE   = 2'h0;
	localparam logic [1:0] SRC_FIRST  = 2'h1;
	localparam logic [1:0] SRC_SECOND = 2'h2;
	localparam logic [1:0] SRC_BOTH   = 2'h3;

	// Synchroniser depth for the recovered-data inputs
	localparam int unsigned SYNC_STAGES = 2;

endpackage : ltm_pkg

`default_nettype wire

// ---- hw/ltm_mirror_path.sv ----
`timescale 1ns/1ps
`default_nettype none

module ltm_mirror_path (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Recovered data from the two receive ports, asynchronous
	input  wire logic       rxFirstData,
	input  wire logic       rxSecondData,
	// Settings from the register bank
	input  wire logic [1:0] sourceSel,
	input  wire logic       driverEn,
	input  wire logic       txPowerDown,
	// Monitor output
	output logic            monitorData,
	output logic            monitorActive
);

	logic [1:0] rxPins;
	logic [1:0] syncStage1_reg;
	logic [1:0] syncStage2_reg;
	logic       monitorData_reg;
	logic       monitorData_next;
	logic       monitorActive_reg;
	logic       monitorActive_next;

	assign rxPins = {rxSecondData, rxFirstData};

	// Two flops per input before anything looks at the data
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					syncStage1_reg[g] <= 1'b0;
					syncStage2_reg[g] <= 1'b0;
				end else begin
					syncStage1_reg[g] <= rxPins[g];
					syncStage2_reg[g] <= syncStage1_reg[g];
				end
			end
		end
	endgenerate

	always_comb begin
		monitorActive_next = 1'b0;
		monitorData_next   = 1'b0;
		if (driverEn && !txPowerDown) begin
			case (sourceSel)
				ltm_pkg::SRC_FIRST: begin
					monitorActive_next = 1'b1;
					monitorData_next   = syncStage2_reg[0];
				end
				ltm_pkg::SRC_SECOND: begin
					monitorActive_next = 1'b1;
					monitorData_next   = syncStage2_reg[1];
				end
				default: begin
					monitorActive_next = 1'b0;
					monitorData_next   = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			monitorData_reg   <= 1'b0;
			monitorActive_reg <= 1'b0;
		end else begin
			monitorData_reg   <= monitorData_next;
			monitorActive_reg <= monitorActive_next;
		end
	end

	assign monitorData   = monitorData_reg;
	assign monitorActive = monitorActive_reg;

endmodule : ltm_mirror_path

`default_nettype wire

// ---- bench/ltm_rx_partner.sv ----
`timescale 1ns/1ps
`default_nettype none

module ltm_rx_partner (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Pace: one new bit each cycle, or one each four cycles
	input  wire logic slow,
	// Recovered serial streams of the two receive ports
	output logic      rxFirstData,
	output logic      rxSecondData,
	// Stream values as sampled three edges back
	output logic      expFirst,
	output logic      expSecond
);
	logic [7:0] lfsr_reg;
	logic [1:0] pace_reg;
	logic [2:0] histFirst_reg;
	logic [2:0] histSecond_reg;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_reg       <= 8'h5b;
			pace_reg       <= 2'h0;
			histFirst_reg  <= 3'h0;
			histSecond_reg <= 3'h0;
		end else begin
			pace_reg <= pace_reg + 2'h1;
			if (!slow || pace_reg == 2'h0) begin
				lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
			end
			histFirst_reg  <= {histFirst_reg[1:0], rxFirstData};
			histSecond_reg <= {histSecond_reg[1:0], rxSecondData};
		end
	end

	// Second stream inverted so a wrong port choice shows quickly
	assign rxFirstData  = lfsr_reg[0];
	assign rxSecondData = ~lfsr_reg[4];
	assign expFirst     = histFirst_reg[2];
	assign expSecond    = histSecond_reg[2];
endmodule : ltm_rx_partner

`default_nettype wire

// ---- bench/loopthrough_monitor_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module loopthrough_monitor_control_test;
	logic        clk_sys;
	logic        rst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] datW;
	logic [31:0] datR;
	logic        ack;
	logic        rxFirstData;
	logic        rxSecondData;
	logic        monitorData;
	logic        monitorDriveOn;
	logic        loopTxPowerDown;
	logic        slow;
	logic        expFirst;
	logic        expSecond;
	logic [31:0] rd;
	int          fail_count;
	int          cmp_count;

	ltm_loop_monitor_ctl ltm_loop_monitor_ctl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .rxFirstData(rxFirstData),
		.rxSecondData(rxSecondData), .monitorData(monitorData),
		.monitorDriveOn(monitorDriveOn), .loopTxPowerDown(loopTxPowerDown));

	ltm_rx_partner ltm_rx_partner_inst (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
		.rxFirstData(rxFirstData), .rxSecondData(rxSecondData),
		.expFirst(expFirst), .expSecond(expSecond));

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		cmp_count++;
		if (seen !== expv) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic wb_cycle(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk_sys);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'h0};
		sel  <= s;
		datW <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 16);
		check({31'h0, ack}, 32'h1);
		rd = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb_cycle

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb_cycle(1'b1, idx, d, 4'h1);
	endtask : wr

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
		wb_cycle(1'b0, idx, 8'h00, 4'hf);
		check(rd, {24'h0, e});
	endtask : rdchk

	// Compares the monitor stream with the chosen port, delayed by the pipe
	task automatic watch(input logic [1:0] code, input logic on);
		logic e;
		repeat (3) @(posedge clk_sys);
		repeat (12) begin
			@(posedge clk_sys);
			e = on && (code == 2'h1 ? expFirst : (code == 2'h2 ? expSecond : 1'b0));
			check({31'h0, monitorData}, {31'h0, e});
		end
	endtask : watch

	task automatic t_reset_values;
		check({29'h0, monitorData, monitorDriveOn, loopTxPowerDown}, 32'h0);
		rdchk(8'h56, 8'h00);
		rdchk(8'h57, 8'h00);
		rdchk(8'h63, 8'h00);
		rdchk(8'h52, 8'h00);
	endtask : t_reset_values

	task automatic t_reserved;
		logic [7:0] idx [4] = '{8'h52, 8'h56, 8'h57, 8'h63};
		logic [7:0] msk [4] = '{8'h80, 8'h08, 8'h06, 8'h01};
		for (int i = 0; i < 4; i++) begin
			wr(idx[i], 8'hff);
			rdchk(idx[i], msk[i]);
			wb_cycle(1'b1, idx[i], 8'h00, 4'h0);
			rdchk(idx[i], msk[i]);
			wr(idx[i], 8'h00);
		end
		wr(8'h40, 8'hff);
		rdchk(8'h40, 8'h00);
	endtask : t_reserved

	task automatic t_routing;
		wr(8'h56, 8'h08);
		check({31'h0, monitorDriveOn}, 32'h1);
		for (int c = 0; c < 4; c++) begin
			// Port selector kept consistent with the source field
			wr(8'h52, c == 2 ? 8'h80 : 8'h00);
			wr(8'h57, {5'h0, c[1:0], 1'b0});
			watch(c[1:0], 1'b1);
			rdchk(8'h58, (c == 1 || c == 2) ? 8'h03 : 8'h00);
		end
		slow <= 1'b1;
		wr(8'h57, 8'h02);
		watch(2'h1, 1'b1);
	endtask : t_routing

	task automatic t_gate;
		wr(8'h56, 8'h00);
		check({31'h0, monitorDriveOn}, 32'h0);
		watch(2'h1, 1'b0);
		rdchk(8'h58, 8'h02);
		wr(8'h56, 8'h08);
		watch(2'h1, 1'b1);
	endtask : t_gate

	task automatic t_powerdown;
		// Stage powered down first, as pattern generation would require
		wr(8'h63, 8'h01);
		check({31'h0, loopTxPowerDown}, 32'h1);
		rdchk(8'h63, 8'h01);
		watch(2'h1, 1'b0);
		rdchk(8'h58, 8'h02);
		wr(8'h63, 8'h00);
		check({31'h0, loopTxPowerDown}, 32'h0);
		watch(2'h1, 1'b1);
	endtask : t_powerdown

	// Reset in mid-run must clear every setting written before it
	task automatic t_midreset;
		// Second port named by both selectors
		wr(8'h52, 8'h80);
		wr(8'h57, 8'h04);
		wr(8'h63, 8'h01);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check({29'h0, monitorData, monitorDriveOn, loopTxPowerDown}, 32'h0);
		rst_n <= 1'b1;
		rdchk(8'h56, 8'h00);
		rdchk(8'h57, 8'h00);
		rdchk(8'h63, 8'h00);
		rdchk(8'h52, 8'h00);
		rdchk(8'h58, 8'h00);
	endtask : t_midreset

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial begin
		#(25 * 6000);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		fail_count = 0;
		cmp_count  = 0;
		rst_n = 1'b0;
		cyc   = 1'b0;
		stb   = 1'b0;
		we    = 1'b0;
		adr   = 10'h0;
		sel   = 4'h0;
		datW  = 32'h0;
		slow  = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset_values();
		t_reserved();
		t_routing();
		t_gate();
		t_powerdown();
		t_midreset();
		tally_and_finish();
	end
endmodule : loopthrough_monitor_control_test

`default_nettype wire
